// ==== src/evc_pkg.sv ====
// Package with register map, field layout and carrier types of the event counter front end
// ==========================================================================
// How it works
// - One enable bit gates all event counting
// - Read-only reserved bits read zero, ignore writes
// - Control bit 7 picks rising or falling edge
// - Span field enables inputs zero through N
// - Output-direction pins never set their flag
// - Status is 16 bits, upper byte zero
// - One pending flag per input, reset zero
// - Counter choice comes only from pending flags
// - Status read never changes any flag
// - Selected edge sets flag, address code follows
// - Request high while any flag is set
// - Address code is twice the served index
// - Completed transfer clears the served flag
// ==========================================================================
package evc_pkg;

  // ========================================================================
  // Register map
  localparam logic [7:0]  EVC_ENABLE_OFFSET  = 8'h00;
  localparam logic [7:0]  EVC_CONTROL_OFFSET = 8'h04;
  localparam logic [7:0]  EVC_STATUS_OFFSET  = 8'h08;
  localparam logic [7:0]  EVC_ENABLE_RESET   = 8'h00;
  localparam logic [7:0]  EVC_CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  EVC_FLAGS_RESET    = 8'h00;

  // ========================================================================
  // Field layout
  localparam int          EVC_ENABLE_BIT     = 7;
  localparam int          EVC_EDGE_BIT       = 7;
  localparam int          EVC_SPAN_MSB       = 2;
  localparam logic [7:0]  EVC_ENABLE_RW_MASK = 8'h8f;
  localparam logic [7:0]  EVC_CONTROL_RW_MASK = 8'h8f;
  localparam int          EVC_CHANNELS       = 8;
  localparam int          EVC_STATUS_WIDTH   = 16;
  localparam int          EVC_CODE_WIDTH     = 5;

  // ========================================================================
  // Carrier types
  typedef struct packed {
    logic       request;
    logic [4:0] addr_code;
  } evc_xfer_type;

  typedef struct packed {
    logic       done;
    logic [2:0] index;
  } evc_clear_type;

endpackage : evc_pkg

// ==== src/evc_edge_sync.sv ====
// Pin synchroniser and selectable edge detector for all event inputs
`timescale 1ns/1ps

module evc_edge_sync
  import evc_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [EVC_CHANNELS-1:0] pin_async,
  input  wire logic                    falling_sel,
  output logic      [EVC_CHANNELS-1:0] edge_hit
);

  logic [EVC_CHANNELS-1:0] meta_reg;
  logic [EVC_CHANNELS-1:0] sync_reg;
  logic [EVC_CHANNELS-1:0] prev_reg;

  // ========================================================================
  // Two-stage synchroniser, then history stage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // ========================================================================
  // Per-channel edge detect, one shared edge select for all channels
  genvar g;
  generate
    for (g = 0; g < EVC_CHANNELS; g++)
    begin : g_edge
      assign edge_hit[g] = falling_sel ? (prev_reg[g] & ~sync_reg[g])
                                       : (~prev_reg[g] & sync_reg[g]);
    end
  endgenerate

endmodule : evc_edge_sync

// ==== src/evc_counter_top.sv ====
// Event counter front end: APB registers, pending flags and transfer request
`timescale 1ns/1ps

module evc_counter_top
  import evc_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic                         pready,
  output logic      [31:0]             prdata,
  output logic                         pslverr,
  input  wire logic [EVC_CHANNELS-1:0] event_pins,
  input  wire logic [EVC_CHANNELS-1:0] port_direction_bit,
  input  wire evc_clear_type           served_clear,
  output evc_xfer_type                 transfer_controller
);

  // ========================================================================
  // Decoding helpers
  function automatic logic [EVC_CHANNELS-1:0] span_mask(input logic [2:0] span);
    logic [EVC_CHANNELS-1:0] mask;
    mask = '0;
    for (int i = 0; i < EVC_CHANNELS; i++)
    begin
      if (i <= int'(span))
      begin
        mask[i] = 1'b1;
      end
    end
    return mask;
  endfunction : span_mask

  function automatic logic [2:0] lowest_index(input logic [EVC_CHANNELS-1:0] flags);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = EVC_CHANNELS - 1; i >= 0; i--)
    begin
      if (flags[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest_index

  // ========================================================================
  // Declarations
  logic [7:0]              enable_reg;
  logic [7:0]              control_reg;
  logic [EVC_CHANNELS-1:0] flags_reg;
  logic [EVC_CHANNELS-1:0] flags_next;
  logic [31:0]             prdata_reg;
  logic                    req_reg;
  logic [4:0]              code_reg;
  logic [EVC_CHANNELS-1:0] edge_hit;
  logic [EVC_CHANNELS-1:0] set_mask;
  logic [EVC_CHANNELS-1:0] clr_mask;
  logic                    count_function_enable;
  logic                    edge_polarity_select;
  logic [2:0]              channel_span_select;
  logic                    setup_phase;
  logic                    access_phase;
  logic                    addr_enable;
  logic                    addr_control;
  logic                    addr_status;
  logic                    addr_known;
  logic                    wr_take;
  logic [31:0]             read_word;

  assign count_function_enable = enable_reg[EVC_ENABLE_BIT];
  assign edge_polarity_select  = control_reg[EVC_EDGE_BIT];
  assign channel_span_select   = control_reg[EVC_SPAN_MSB:0];

  // ========================================================================
  // Pin front end
  evc_edge_sync u_edge
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .pin_async   (event_pins),
    .falling_sel (edge_polarity_select),
    .edge_hit    (edge_hit)
  );

  // ========================================================================
  // APB decode
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_enable  = (paddr == EVC_ENABLE_OFFSET);
  assign addr_control = (paddr == EVC_CONTROL_OFFSET);
  assign addr_status  = (paddr == EVC_STATUS_OFFSET);
  assign addr_known   = addr_enable | addr_control | addr_status;
  assign wr_take      = access_phase & pwrite & pstrb[0];

  // Zero-wait slave; status is read-only, so writes there are errors
  assign pready  = 1'b1;
  assign pslverr = access_phase & (~addr_known | (pwrite & addr_status));
  assign prdata  = prdata_reg;

  // ========================================================================
  // Enable register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_reg <= EVC_ENABLE_RESET;
    end
    else if (wr_take && addr_enable)
    begin
      enable_reg <= pwdata[7:0] & EVC_ENABLE_RW_MASK;
    end
  end

  // ========================================================================
  // Control register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg <= EVC_CONTROL_RESET;
    end
    else if (wr_take && addr_control)
    begin
      control_reg <= pwdata[7:0] & EVC_CONTROL_RW_MASK;
    end
  end

  // ========================================================================
  // Read data, captured in the setup cycle
  always_comb
  begin
    read_word = 32'h0000_0000;
    if (addr_enable)
    begin
      read_word[7:0] = enable_reg;
    end
    else if (addr_control)
    begin
      read_word[7:0] = control_reg;
    end
    else if (addr_status)
    begin
      read_word[EVC_STATUS_WIDTH-1:0] = {8'h00, flags_reg};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (setup_phase && !pwrite)
    begin
      prdata_reg <= read_word;
    end
  end

  // ========================================================================
  // Pending flags
  assign set_mask = edge_hit & span_mask(channel_span_select)
                  & ~port_direction_bit
                  & {EVC_CHANNELS{count_function_enable}};

  always_comb
  begin
    clr_mask = '0;
    if (served_clear.done)
    begin
      clr_mask[served_clear.index] = 1'b1;
    end
  end

  // Set wins over clear; a set on a pending flag just holds it
  assign flags_next = (flags_reg & ~clr_mask) | set_mask;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg <= EVC_FLAGS_RESET;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  // ========================================================================
  // Request and address code toward the transfer controller
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_reg  <= 1'b0;
      code_reg <= 5'h00;
    end
    else
    begin
      req_reg  <= |flags_next;
      code_reg <= {1'b0, lowest_index(flags_next), 1'b0};
    end
  end

  assign transfer_controller.request   = req_reg;
  assign transfer_controller.addr_code = code_reg;

  // ========================================================================
  // Checks
  logic [EVC_CHANNELS-1:0] new_bits;
  logic [EVC_CHANNELS-1:0] flags_prev_reg;

  // Last cycle's flags, for the new-flag cover
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_prev_reg <= EVC_FLAGS_RESET;
    end
    else
    begin
      flags_prev_reg <= flags_reg;
    end
  end

  assign new_bits = flags_reg & ~flags_prev_reg;

  property p_disabled_quiet;
    @(posedge clock) disable iff (!rst_n)
    !count_function_enable |=> ((flags_reg & ~$past(flags_reg)) == 8'h00);
  endproperty

  disabled_no_set_a : assert property (p_disabled_quiet)
    else $error("flag set while counting disabled");

  enable_reserved_a : assert property (@(posedge clock) disable iff (!rst_n)
    (setup_phase && !pwrite && addr_enable) |=> (prdata[6:4] == 3'h0)
      && (prdata[31:8] == 24'h000000))
    else $error("enable reserved bits not zero");

  control_reserved_a : assert property (@(posedge clock) disable iff (!rst_n)
    (wr_take && addr_control) |=> (control_reg[6:4] == 3'h0)
      && (control_reg[3:0] == $past(pwdata[3:0])))
    else $error("control reserved bits not kept zero");

  polarity_edge_a : assert property (@(posedge clock) disable iff (!rst_n)
    (count_function_enable && channel_span_select == 3'h7 && port_direction_bit == 8'h00
      && edge_polarity_select && !served_clear.done)
      ##0 $fell(u_edge.sync_reg[0]) |=> flags_reg[0])
    else $error("falling edge not caught");

  span_limit_a : assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> ((flags_reg & ~$past(flags_reg) & ~span_mask($past(channel_span_select)))
      == 8'h00))
    else $error("flag set outside channel span");

  direction_block_a : assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> ((flags_reg & ~$past(flags_reg) & $past(port_direction_bit)) == 8'h00))
    else $error("flag set on output pin");

  status_upper_a : assert property (@(posedge clock) disable iff (!rst_n)
    (setup_phase && !pwrite && addr_status) ##1 access_phase
      |-> (prdata[31:8] == 24'h000000) && (prdata[7:0] == $past(flags_reg)))
    else $error("status read wrong");

  hit_sets_a : assert property (@(posedge clock) disable iff (!rst_n)
    (set_mask != 8'h00) |=> ((flags_reg & $past(set_mask)) == $past(set_mask)))
    else $error("selected edge lost");

  read_keeps_a : assert property (@(posedge clock) disable iff (!rst_n)
    (access_phase && !pwrite && !served_clear.done) |=> ((~flags_reg & $past(flags_reg))
      == 8'h00))
    else $error("read changed flags");

  request_level_a : assert property (@(posedge clock) disable iff (!rst_n)
    transfer_controller.request == (flags_reg != 8'h00))
    else $error("request does not follow flags");

  code_lowest_a : assert property (@(posedge clock) disable iff (!rst_n)
    transfer_controller.request |-> (transfer_controller.addr_code[0] == 1'b0)
      && flags_reg[transfer_controller.addr_code[3:1]]
      && ((flags_reg & ((8'h01 << transfer_controller.addr_code[3:1]) - 8'h01)) == 8'h00))
    else $error("address code not lowest pending");

  clear_served_a : assert property (@(posedge clock) disable iff (!rst_n)
    (served_clear.done && !set_mask[served_clear.index])
      |=> !flags_reg[$past(served_clear.index)])
    else $error("served flag not cleared");

  set_beats_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    (served_clear.done && set_mask[served_clear.index])
      |=> flags_reg[$past(served_clear.index)])
    else $error("set lost to clear");

  cov_edge_c     : cover property (@(posedge clock) disable iff (!rst_n) new_bits != 8'h00);
  cov_clear_c    : cover property (@(posedge clock) disable iff (!rst_n)
    served_clear.done && flags_reg[served_clear.index]);
  cov_multi_c    : cover property (@(posedge clock) disable iff (!rst_n)
    $countones(flags_reg) > 1);
  cov_ctrl_wr_c  : cover property (@(posedge clock) disable iff (!rst_n)
    wr_take && addr_control);

endmodule : evc_counter_top

// ==== tb/evc_xfer_model.sv ====
// Transfer controller model that serves pending events one at a time
`timescale 1ns/1ps

module evc_xfer_model
  import evc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         serve_en,
  input  wire logic         slow,
  input  wire evc_xfer_type xfer,
  output evc_clear_type     clear
);
  logic [2:0] gap_reg;

  // ==========================================================================
  // Serve loop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clear   <= '0;
      gap_reg <= '0;
    end
    else
    begin
      clear.done  <= 1'b0;
      // Index wanders while no clear is offered
      clear.index <= clear.index + 3'd1;
      if (gap_reg != 3'd0)
        gap_reg <= gap_reg - 3'd1;
      else if (serve_en && xfer.request)
      begin
        clear.done  <= 1'b1;
        clear.index <= xfer.addr_code[3:1];
        // Request settles one edge after the clear
        gap_reg     <= slow ? 3'd5 : 3'd1;
      end
    end
  end
endmodule : evc_xfer_model

// ==== tb/testbench.sv ====
// Self-checking bench for the event counter front end
`timescale 1ns/1ps

module testbench
  import evc_pkg::*;
;
  logic          clock;
  logic          rst_n;
  logic          psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata;
  logic [3:0]    pstrb;
  logic [7:0]    event_pins, port_direction_bit, dir, idle, mask;
  evc_clear_type served_clear;
  evc_xfer_type  transfer_controller;
  logic          serve_en, slow, fall;
  logic [2:0]    span;
  logic [33:0]   exp_q[$];
  logic [33:0]   e_now;
  int            n_errors, total_checks, it, k, lo;
  integer        seed = 32'h38a1;

  always #10 clock = ~clock;

  evc_counter_top evc_counter_top_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .event_pins(event_pins),
    .port_direction_bit(port_direction_bit), .served_clear(served_clear),
    .transfer_controller(transfer_controller));

  evc_xfer_model evc_xfer_model_i (.clock(clock), .rst_n(rst_n), .serve_en(serve_en),
    .slow(slow), .xfer(transfer_controller), .clear(served_clear));

  // ==========================================================================
  // Checking
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task close_out;
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // One APB transfer; the expected answer goes to the queue
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic err, input logic [31:0] exp);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    exp_q.push_back({wr, err, exp});
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clock);
    end
    if (n == 50)
      n_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge clock)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      e_now = exp_q.pop_front();
      check("pslverr", 32'(pslverr), 32'(e_now[32]));
      if (!e_now[33])
        check("prdata", prdata, e_now[31:0]);
    end

  initial
  begin
    #200_000;
    n_errors++;
    close_out;
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    clock = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; event_pins = 8'h00;
    port_direction_bit = 8'h00; serve_en = 1'b0; slow = 1'b0;
    n_errors = 0; total_checks = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, EVC_ENABLE_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    apb(1'b0, EVC_CONTROL_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    apb(1'b0, EVC_STATUS_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    apb(1'b1, EVC_ENABLE_OFFSET, 32'h70, 4'hf, 1'b0, 32'h0);
    apb(1'b0, EVC_ENABLE_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    apb(1'b1, EVC_CONTROL_OFFSET, 32'h75, 4'hf, 1'b0, 32'h0);
    apb(1'b0, EVC_CONTROL_OFFSET, 32'h0, 4'hf, 1'b0, 32'h05);
    apb(1'b1, EVC_ENABLE_OFFSET, 32'h80, 4'h0, 1'b0, 32'h0);
    apb(1'b0, EVC_ENABLE_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, 4'hf, 1'b1, 32'h0);
    apb(1'b1, EVC_STATUS_OFFSET, 32'hff, 4'hf, 1'b1, 32'h0);
    // Edges while the function is off
    event_pins <= 8'hff;
    repeat (8) @(posedge clock);
    apb(1'b0, EVC_STATUS_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    check("request", 32'(transfer_controller.request), 32'h0);
    for (it = 0; it < 8; it++)
    begin
      span = 3'($random(seed));
      dir  = 8'($random(seed));
      fall = it[0];
      slow <= 1'($random(seed));
      idle = fall ? 8'hff : 8'h00;
      mask = 8'((9'h2 << span) - 9'h1) & ~dir;
      lo = 0;
      for (k = 7; k >= 0; k--)
        if (mask[k])
          lo = k;
      apb(1'b1, EVC_ENABLE_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
      event_pins <= idle;
      port_direction_bit <= dir;
      repeat (6) @(posedge clock);
      apb(1'b1, EVC_CONTROL_OFFSET, {24'h0, fall, 4'h0, span}, 4'hf, 1'b0, 32'h0);
      apb(1'b1, EVC_ENABLE_OFFSET, 32'h80, 4'hf, 1'b0, 32'h0);
      event_pins <= ~idle;
      repeat (8) @(posedge clock);
      // Back to idle and a repeat edge while still pending
      event_pins <= idle;
      repeat (6) @(posedge clock);
      event_pins <= ~idle;
      repeat (8) @(posedge clock);
      apb(1'b0, EVC_STATUS_OFFSET, 32'h0, 4'hf, 1'b0, {24'h0, mask});
      apb(1'b0, EVC_STATUS_OFFSET, 32'h0, 4'hf, 1'b0, {24'h0, mask});
      check("request", 32'(transfer_controller.request), 32'(mask != 8'h00));
      check("addr_code", 32'(transfer_controller.addr_code), 32'(2 * lo));
      serve_en <= 1'b1;
      repeat (80) @(posedge clock);
      serve_en <= 1'b0;
      apb(1'b0, EVC_STATUS_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
      check("request", 32'(transfer_controller.request), 32'h0);
      // Opposite edge while enabled
      event_pins <= idle;
      repeat (8) @(posedge clock);
      apb(1'b0, EVC_STATUS_OFFSET, 32'h0, 4'hf, 1'b0, 32'h0);
    end
    close_out;
  end
endmodule : testbench
